// ==== pkg/ctb_pkg.sv ====
// constants and carrier types for the calendar and timer bit block
// assumes a 250 MHz system clock and a date/time source on the same clock
package ctb_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int N_CAL = 16;
    localparam int N_TMR = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DLY_W = 16;

    // ----------------------------------------
    // time base
    // ----------------------------------------
    localparam int CLK_HZ = 32'h0EE6B280;         // 250 MHz
    localparam int TICK_S = 32'h00000001;         // base unit, seconds
    localparam int SEC_CYCLES = CLK_HZ * TICK_S;
    localparam int SEC_PER_MIN = 32'h0000003C;
    localparam int MIN_PER_HR = 32'h0000003C;
    localparam logic [10:0] MIN_PER_HR_11 = 11'h03C;

    // ----------------------------------------
    // register map, word addresses
    // ----------------------------------------
    localparam logic [7:0] A_WEEKLY = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h01;
    localparam logic [1:0] CAL_SPACE = 2'h1;      // 0x40..0x7F, 4 words each
    localparam logic [3:0] TMR_SPACE = 4'h8;      // 0x80..0x8F, 4 words each
    localparam logic [1:0] F_MONTH = 2'h0;
    localparam logic [1:0] F_DAY = 2'h1;
    localparam logic [1:0] F_START = 2'h2;
    localparam logic [1:0] F_END = 2'h3;
    localparam logic [1:0] F_MODE = 2'h0;
    localparam logic [1:0] F_ACT = 2'h1;
    localparam logic [1:0] F_DEA = 2'h2;

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int WDAY_LSB = 16;                 // day mask weekday bits 16..22
    localparam int OCC_LAST = 4;                  // occurrence bits 0..4
    localparam int BASE_LSB = 16;                 // delay word: base in 17:16

    // ----------------------------------------
    // codes
    // ----------------------------------------
    localparam logic [2:0] M_UNUSED = 3'h0;
    localparam logic [2:0] M_DELAY = 3'h1;
    localparam logic [2:0] M_PULSE = 3'h2;
    localparam logic [2:0] M_FREE = 3'h3;
    localparam logic [2:0] M_SETRST = 3'h4;
    localparam logic [1:0] B_SEC = 2'h0;
    localparam logic [1:0] B_MIN = 2'h1;

    // current date and time, month 1..12, day 1..31, weekday 0 = sunday
    typedef struct packed {
        logic [3:0] month;
        logic [4:0] mday;
        logic [2:0] wday;
        logic [4:0] mlen;
        logic [4:0] hour;
        logic [5:0] minute;
    } ctb_now_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] act_base;
        logic [DLY_W-1:0] act_val;
        logic [1:0] dea_base;
        logic [DLY_W-1:0] dea_val;
    } ctb_tmr_cfg_t;

endpackage

// ==== rtl/ctb_calendar_timer.sv ====
// calendar matchers and general timers producing status bits for a logic engine
// assumes date/time and timer conditions come from logic on clk; registers via plain port
//
// Overview of operation
// - sixteen calendars; one shared mask bit per calendar, set means weekly
// - twelve-bit month mask, bit 0 january; bit only in selected months
// - monthly calendar: day mask bits 0..30 pick days 1..31
// - weekly calendar: day mask bits 16..22 pick sunday..saturday
// - weekly low bits 0..4 select first, second, third, fourth, last occurrence
// - no occurrence bit set means every week matches
// - last occurrence is the final one, fourth or fifth
// - bit only inside the time slot on a matching day; one slot for all days
// - slot start equal to end selects the whole day
// - start after end: on after start, off after end next day
// - four timers, each one bit, with activation and reset conditions
// - reset condition forces timer bit low in every mode
// - two delays each with value and base: seconds, minutes, hours
// - mode 0 keeps the bit low
// - delay mode: set after activation delay once condition true
// - delay mode: clear after deactivation delay once condition false
// - pulse mode: rising condition gives pulse of activation delay
// - pulse mode: falling condition gives pulse of deactivation delay
// - free run: low while inactive, else high act delay, low deact delay
// - set/reset: activation sets, hold when both conditions false
`timescale 1ns/1ps

module ctb_calendar_timer #(
    parameter int SEC_CYCLES = ctb_pkg::SEC_CYCLES,
    parameter int SEC_PER_MIN = ctb_pkg::SEC_PER_MIN,
    parameter int MIN_PER_HR = ctb_pkg::MIN_PER_HR
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ctb_pkg::ADDR_W-1:0] addr,
    input wire logic [ctb_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [ctb_pkg::DATA_W-1:0] rdata,
    input wire ctb_pkg::ctb_now_t now,
    input wire logic [ctb_pkg::N_TMR-1:0] act_cond,
    input wire logic [ctb_pkg::N_TMR-1:0] rst_cond,
    output logic [ctb_pkg::N_CAL-1:0] first_calendar_status_bit,
    output logic [ctb_pkg::N_TMR-1:0] tmr_bits
);

    localparam int NC = ctb_pkg::N_CAL;
    localparam int NT = ctb_pkg::N_TMR;
    localparam int DW = ctb_pkg::DLY_W;

    // ----------------------------------------
    // time base enables
    // ----------------------------------------
    logic [31:0] div_r;
    logic [5:0] sec_cnt_r;
    logic [5:0] min_cnt_r;
    logic sec_tick_r;
    logic min_tick_r;
    logic hr_tick_r;
    wire div_end = div_r == 32'(SEC_CYCLES - 1);
    wire sec_end = sec_cnt_r == 6'(SEC_PER_MIN - 1);
    wire min_end = min_cnt_r == 6'(MIN_PER_HR - 1);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_r <= 32'h00000000;
            sec_cnt_r <= 6'h00;
            min_cnt_r <= 6'h00;
            sec_tick_r <= 1'b0;
            min_tick_r <= 1'b0;
            hr_tick_r <= 1'b0;
        end else begin
            div_r <= div_end ? 32'h00000000 : div_r + 32'h00000001;
            sec_tick_r <= div_end;
            min_tick_r <= div_end && sec_end;
            hr_tick_r <= div_end && sec_end && min_end;
            if (div_end) begin
                sec_cnt_r <= sec_end ? 6'h00 : sec_cnt_r + 6'h01;
                if (sec_end) begin
                    min_cnt_r <= min_end ? 6'h00 : min_cnt_r + 6'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    logic [NC-1:0] weekly_r;
    logic [11:0] month_r [NC];
    logic [30:0] day_r [NC];
    logic [10:0] start_r [NC];
    logic [10:0] end_r [NC];
    ctb_pkg::ctb_tmr_cfg_t cfg_r [NT];
    logic [NC-1:0] cal_r;
    logic [NT-1:0] tmr_r;
    localparam int DATA_W_L = ctb_pkg::DATA_W;
    logic [DATA_W_L-1:0] rdata_r;

    wire cal_hit = addr[7:6] == ctb_pkg::CAL_SPACE;
    wire tmr_hit = addr[7:4] == ctb_pkg::TMR_SPACE;
    wire [3:0] cal_idx = addr[5:2];
    wire [1:0] tmr_idx = addr[3:2];
    wire [1:0] fld = addr[1:0];

    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h00000000;
        if (addr == ctb_pkg::A_WEEKLY) begin
            rd_val = {16'h0000, weekly_r};
        end else if (addr == ctb_pkg::A_STATUS) begin
            rd_val = {12'h000, tmr_r, cal_r};
        end else if (cal_hit && fld == ctb_pkg::F_MONTH) begin
            rd_val = {20'h00000, month_r[cal_idx]};
        end else if (cal_hit && fld == ctb_pkg::F_DAY) begin
            rd_val = {1'b0, day_r[cal_idx]};
        end else if (cal_hit && fld == ctb_pkg::F_START) begin
            rd_val = {21'h000000, start_r[cal_idx]};
        end else if (cal_hit) begin
            rd_val = {21'h000000, end_r[cal_idx]};
        end else if (tmr_hit && fld == ctb_pkg::F_MODE) begin
            rd_val = {29'h00000000, cfg_r[tmr_idx].mode};
        end else if (tmr_hit && fld == ctb_pkg::F_ACT) begin
            rd_val = {14'h0000, cfg_r[tmr_idx].act_base, cfg_r[tmr_idx].act_val};
        end else if (tmr_hit && fld == ctb_pkg::F_DEA) begin
            rd_val = {14'h0000, cfg_r[tmr_idx].dea_base, cfg_r[tmr_idx].dea_val};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rd ? rd_val : 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            weekly_r <= 16'h0000;
        end else if (wr && addr == ctb_pkg::A_WEEKLY) begin
            weekly_r <= wdata[15:0];
        end
    end

    // ----------------------------------------
    // shared date decode
    // ----------------------------------------
    wire [11:0] mon_hot = 12'(16'h0001 << (now.month - 4'h1));
    wire [30:0] mday_hot = 31'(32'h00000001 << (now.mday - 5'h01));
    wire [6:0] wday_hot = 7'(8'h01 << now.wday);
    logic [4:0] occ_vec;
    // fifth occurrence is reachable only through the last selector
    assign occ_vec[0] = now.mday <= 5'h07;
    assign occ_vec[1] = now.mday > 5'h07 && now.mday <= 5'h0E;
    assign occ_vec[2] = now.mday > 5'h0E && now.mday <= 5'h15;
    assign occ_vec[3] = now.mday > 5'h15 && now.mday <= 5'h1C;
    assign occ_vec[4] = 6'(now.mday) + 6'h07 > 6'(now.mlen);
    wire [10:0] tod = 11'(now.hour) * ctb_pkg::MIN_PER_HR_11 + 11'(now.minute);

    logic [4:0] last_mday_r;
    wire new_day = now.mday != last_mday_r;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            last_mday_r <= 5'h00;
        end else begin
            last_mday_r <= now.mday;
        end
    end

    // ----------------------------------------
    // calendars
    // ----------------------------------------
    for (genvar c = 0; c < NC; c++) begin : g_cal
        logic day_ok_r;
        logic prev_ok_r;
        wire [4:0] occ_sel = day_r[c][ctb_pkg::OCC_LAST:0];
        wire wk_day = |(day_r[c][ctb_pkg::WDAY_LSB +: 7] & wday_hot);
        wire wk_occ = occ_sel == 5'h00 || |(occ_sel & occ_vec);
        wire mo_day = |(day_r[c] & mday_hot);
        wire mon_ok = |(month_r[c] & mon_hot);
        wire day_ok = mon_ok && (weekly_r[c] ? wk_day && wk_occ : mo_day);
        wire after_s = tod >= start_r[c];
        wire before_e = tod < end_r[c];
        logic hit;
        always_comb begin
            if (start_r[c] == end_r[c]) begin
                hit = day_ok;
            end else if (start_r[c] < end_r[c]) begin
                hit = day_ok && after_s && before_e;
            end else begin
                hit = (day_ok && after_s) || (prev_ok_r && before_e);
            end
        end
        wire cw = wr && cal_hit && cal_idx == 4'(c);

        always_ff @(posedge clk) begin
            if (!reset_n) begin
                month_r[c] <= 12'h000;
                day_r[c] <= 31'h00000000;
                start_r[c] <= 11'h000;
                end_r[c] <= 11'h000;
            end else if (cw && fld == ctb_pkg::F_MONTH) begin
                month_r[c] <= wdata[11:0];
            end else if (cw && fld == ctb_pkg::F_DAY) begin
                day_r[c] <= wdata[30:0];
            end else if (cw && fld == ctb_pkg::F_START) begin
                start_r[c] <= wdata[10:0];
            end else if (cw) begin
                end_r[c] <= wdata[10:0];
            end
        end

        // day_ok_r still holds the old day when the date rolls over
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                day_ok_r <= 1'b0;
                prev_ok_r <= 1'b0;
                cal_r[c] <= 1'b0;
            end else begin
                day_ok_r <= day_ok;
                prev_ok_r <= new_day ? day_ok_r : prev_ok_r;
                cal_r[c] <= hit;
            end
        end
    end

    // ----------------------------------------
    // timers
    // ----------------------------------------
    for (genvar t = 0; t < NT; t++) begin : g_tmr
        logic [DW-1:0] cnt_r;
        logic [DW-1:0] cnt_nxt;
        logic act_d_r;
        logic aux_r;
        logic aux_nxt;
        logic out_nxt;
        logic ph;
        logic tk;
        ctb_pkg::ctb_tmr_cfg_t cf;
        assign cf = cfg_r[t];
        wire act = act_cond[t];
        wire out = tmr_r[t];
        wire [1:0] base = ph ? cf.dea_base : cf.act_base;
        wire [DW-1:0] lim = ph ? cf.dea_val : cf.act_val;
        wire done = cnt_r >= lim;
        wire [DW-1:0] cnt_inc = tk ? cnt_r + 16'h0001 : cnt_r;
        wire rise = act && !act_d_r;
        wire fall = !act && act_d_r;
        wire tw = wr && tmr_hit && tmr_idx == 2'(t);

        // phase picks which of the two delays is being timed
        always_comb begin
            if (cf.mode == ctb_pkg::M_PULSE) begin
                ph = aux_r;
            end else if (cf.mode == ctb_pkg::M_FREE) begin
                ph = !out;
            end else begin
                ph = out;
            end
            if (base == ctb_pkg::B_SEC) begin
                tk = sec_tick_r;
            end else if (base == ctb_pkg::B_MIN) begin
                tk = min_tick_r;
            end else begin
                tk = hr_tick_r;
            end
        end

        always_comb begin
            out_nxt = 1'b0;
            cnt_nxt = 16'h0000;
            aux_nxt = 1'b0;
            if (rst_cond[t]) begin
                out_nxt = 1'b0;
            end else begin
                case (cf.mode)
                    ctb_pkg::M_DELAY: begin
                        out_nxt = out;
                        if (act != out && done) begin
                            out_nxt = act;
                        end else if (act != out) begin
                            cnt_nxt = cnt_inc;
                        end
                    end
                    ctb_pkg::M_PULSE: begin
                        aux_nxt = aux_r;
                        if (rise || fall) begin
                            out_nxt = 1'b1;
                            aux_nxt = fall;
                        end else if (out && !done) begin
                            out_nxt = 1'b1;
                            cnt_nxt = cnt_inc;
                        end
                    end
                    ctb_pkg::M_FREE: begin
                        // a fresh rising edge restarts high even if another mode left aux set
                        if (act && (!aux_r || rise)) begin
                            out_nxt = 1'b1;
                            aux_nxt = 1'b1;
                        end else if (act && done) begin
                            out_nxt = !out;
                            aux_nxt = 1'b1;
                        end else if (act) begin
                            out_nxt = out;
                            aux_nxt = 1'b1;
                            cnt_nxt = cnt_inc;
                        end
                    end
                    ctb_pkg::M_SETRST: begin
                        out_nxt = act || out;
                    end
                    default: begin
                        out_nxt = 1'b0;
                    end
                endcase
            end
        end

        always_ff @(posedge clk) begin
            if (!reset_n) begin
                cfg_r[t] <= '0;
            end else if (tw && fld == ctb_pkg::F_MODE) begin
                cfg_r[t].mode <= wdata[2:0];
            end else if (tw && fld == ctb_pkg::F_ACT) begin
                cfg_r[t].act_base <= wdata[ctb_pkg::BASE_LSB +: 2];
                cfg_r[t].act_val <= wdata[DW-1:0];
            end else if (tw && fld == ctb_pkg::F_DEA) begin
                cfg_r[t].dea_base <= wdata[ctb_pkg::BASE_LSB +: 2];
                cfg_r[t].dea_val <= wdata[DW-1:0];
            end
        end

        always_ff @(posedge clk) begin
            if (!reset_n) begin
                tmr_r[t] <= 1'b0;
                cnt_r <= 16'h0000;
                act_d_r <= 1'b0;
                aux_r <= 1'b0;
            end else begin
                tmr_r[t] <= out_nxt;
                cnt_r <= cnt_nxt;
                act_d_r <= act;
                aux_r <= aux_nxt;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata = rdata_r;
    assign first_calendar_status_bit = cal_r;
    assign tmr_bits = tmr_r;

endmodule // ctb_calendar_timer

// ==== test/ctb_checker_properties.sv ====
// port checker for the calendar and timer bit block
// assumes reset_n synchronous active low on clk; timer modes shadowed from writes
`timescale 1ns/1ps
module ctb_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [3:0] act_cond,
    input wire logic [3:0] rst_cond,
    input wire logic [15:0] first_calendar_status_bit,
    input wire logic [3:0] tmr_bits
);
    // ----
    // mode shadow
    // ----
    logic [2:0] mode_r [4];
    logic [3:0] act_r, idle_v, sr_v, fr_v, set_v, hold_v, rise_v;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_r <= '{default: 3'h0};
            act_r <= 4'h0;
        end else begin
            act_r <= act_cond;
            if (wr && addr[7:4] == 4'h8 && addr[1:0] == 2'h0) begin
                mode_r[addr[3:2]] <= wdata[2:0];
            end
        end
    end
    for (genvar t = 0; t < 4; t++) begin : g_m
        // codes above set/reset act as unused
        assign idle_v[t] = mode_r[t] == 3'h0 || mode_r[t] > 3'h4;
        assign sr_v[t] = mode_r[t] == 3'h4;
        assign fr_v[t] = mode_r[t] == 3'h3;
    end
    assign set_v = act_cond & ~rst_cond & sr_v;
    assign hold_v = ~act_cond & ~rst_cond & sr_v;
    assign rise_v = act_cond & ~act_r & ~rst_cond & fr_v;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_unmapped; rd && addr inside {[8'h02:8'h3F]} |=> rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_status;
        rd && addr == 8'h01 |=> rdata == {12'h0, $past(tmr_bits), $past(first_calendar_status_bit)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_rst; |rst_cond |=> (tmr_bits & $past(rst_cond)) == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset condition ignored");
    property p_idle; (tmr_bits & idle_v & $past(idle_v)) == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("unused timer bit high");
    property p_set; |set_v |=> (tmr_bits & $past(set_v)) == $past(set_v); endproperty
    a_set: assert property (p_set) else $error("set/reset timer not set");
    property p_hold;
        |hold_v |=> ((tmr_bits ^ $past(tmr_bits)) & $past(hold_v)) == 4'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("set/reset timer did not hold");
    property p_free; |rise_v |=> (tmr_bits & $past(rise_v)) == $past(rise_v); endproperty
    a_free: assert property (p_free) else $error("free run did not start high");
endmodule // ctb_checker

bind ctb_calendar_timer ctb_checker u_chk (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .act_cond(act_cond), .rst_cond(rst_cond),
    .first_calendar_status_bit(first_calendar_status_bit), .tmr_bits(tmr_bits));

// ==== test/ctb_engine_model.sv ====
// stand-in for the AND/OR logic engine feeding the timers
// assumes the bench asks for condition levels on clk
`timescale 1ns/1ps
module ctb_engine_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] want_act,
    input wire logic [3:0] want_rst,
    input wire logic [19:0] bits_in,
    output logic [3:0] act_cond,
    output logic [3:0] rst_cond,
    output logic [19:0] seen
);
    // engine terms are evaluated once a cycle, so conditions lag a cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            act_cond <= 4'h0;
            rst_cond <= 4'h0;
            seen <= 20'h0;
        end else begin
            act_cond <= want_act;
            rst_cond <= want_rst;
            seen <= bits_in;
        end
    end
endmodule // ctb_engine_model

// ==== test/testbench.sv ====
// self-checking bench for the calendar and timer bit block
// assumes a shortened time base: 10 cycles a second, 3 s a minute, 3 min an hour
`timescale 1ns/1ps
module testbench;
    logic clk, reset_n, wr, rd;
    logic [7:0] addr;
    logic [31:0] wdata, got;
    logic [31:0] rdata;
    ctb_pkg::ctb_now_t now, n;
    logic [3:0] want_act, want_rst, act_cond, rst_cond, tmr;
    logic [15:0] cal, ecal, wkm;
    logic [19:0] seen;
    logic wk [16];
    logic [11:0] mm [16];
    logic [30:0] dm [16];
    logic [10:0] st [16];
    logic [10:0] en [16];
    logic [4:0] hr [4] = '{5'h15, 5'h17, 5'h01, 5'h03};
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 32'hA80D9EB2;
    int hi, lo;

    ctb_calendar_timer #(.SEC_CYCLES(10), .SEC_PER_MIN(3), .MIN_PER_HR(3)) dut (.clk(clk),
        .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .now(now),
        .act_cond(act_cond), .rst_cond(rst_cond), .first_calendar_status_bit(cal), .tmr_bits(tmr));
    ctb_engine_model eng (.clk(clk), .reset_n(reset_n), .want_act(want_act), .want_rst(want_rst),
        .bits_in({tmr, cal}), .act_cond(act_cond), .rst_cond(rst_cond), .seen(seen));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // runaway guard, well above the under two thousand cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ----
    // helpers
    // ----
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] sv, input logic [31:0] ev);
        checks_done++;
        if (sv !== ev) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, sv, ev);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic cond(input logic [3:0] a, input logic [3:0] r);
        @(posedge clk);
        want_act <= a;
        want_rst <= r;
    endtask
    task automatic tchk(input int k, input int i, input logic v);
        step(k);
        check({31'h0, tmr[i]}, {31'h0, v});
    endtask
    function automatic logic cal_exp(input int c, input ctb_pkg::ctb_now_t v);
        logic [10:0] t;
        logic [4:0] occ;
        logic day;
        t = 11'(v.hour) * 11'h03C + 11'(v.minute);
        occ = 5'h0;
        if (v.mday < 5'h1D) occ[(v.mday - 5'h01) / 5'h07] = 1'b1;
        if (int'(v.mday) + 7 > int'(v.mlen)) occ[4] = 1'b1;
        if (wk[c]) day = dm[c][16 + v.wday] && (dm[c][4:0] == 5'h0 || (dm[c][4:0] & occ) != 5'h0);
        else day = dm[c][v.mday - 5'h01];
        return mm[c][v.month - 4'h1] && day && (st[c] == en[c] || (t >= st[c] && t < en[c]));
    endfunction

    // ----
    // main sequence
    // ----
    initial begin
        reset_n = 1'b0;
        {wr, rd, addr, wdata, want_act, want_rst} = '0;
        now = '0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rreg(8'h01, got);
        check(got, 32'h0);
        wreg(8'h20, 32'hFFFFFFFF);
        rreg(8'h20, got);
        check(got, 32'h0);
        for (int c = 0; c < 16; c++) begin
            wk[c] = c inside {1, 2} ? 1'b1 : 1'($random(seed));
            mm[c] = 12'($random(seed));
            dm[c] = 31'($random(seed));
            if (c == 1) dm[c][4:0] = 5'h00;
            if (c == 2) dm[c][4:0] = 5'h10;
            st[c] = 11'($unsigned($random(seed)) % 1440);
            en[c] = c % 4 == 0 ? st[c] : 11'($unsigned($random(seed)) % 1440);
            if (st[c] > en[c]) {st[c], en[c]} = {en[c], st[c]};
            wkm[c] = wk[c];
            wreg({2'h1, 4'(c), 2'h0}, {20'h0, mm[c]});
            wreg({2'h1, 4'(c), 2'h1}, {1'h0, dm[c]});
            wreg({2'h1, 4'(c), 2'h2}, {21'h0, st[c]});
            wreg({2'h1, 4'(c), 2'h3}, {21'h0, en[c]});
        end
        wreg(8'h00, {16'h0, wkm});
        rreg(8'h00, got);
        check(got, {16'h0, wkm});
        for (int i = 0; i < 300; i++) begin
            n.mlen = 5'(28 + $unsigned($random(seed)) % 4);
            n.month = 4'(1 + $unsigned($random(seed)) % 12);
            n.mday = 5'(1 + $unsigned($random(seed)) % n.mlen);
            n.wday = 3'($unsigned($random(seed)) % 7);
            n.hour = 5'($unsigned($random(seed)) % 24);
            n.minute = 6'($unsigned($random(seed)) % 60);
            @(posedge clk);
            now <= n;
            step(2);
            for (int c = 0; c < 16; c++) ecal[c] = cal_exp(c, n);
            check({16'h0, cal}, {16'h0, ecal});
        end
        rreg(8'h01, got);
        check(got, {16'h0, ecal});
        check({12'h0, seen}, {16'h0, ecal});
        // slot across midnight on day 10 only
        wreg(8'h00, {16'h0, wkm & 16'hFFFE});
        wreg(8'h40, 32'h00000FFF);
        wreg(8'h41, 32'h00000200);
        wreg(8'h42, 32'h00000528);
        wreg(8'h43, 32'h00000078);
        n = '{month: 4'h1, mday: 5'h0A, wday: 3'h0, mlen: 5'h1F, hour: 5'h0, minute: 6'h00};
        for (int i = 0; i < 4; i++) begin
            n.mday = i < 2 ? 5'h0A : 5'h0B;
            n.hour = hr[i];
            @(posedge clk);
            now <= n;
            step(3);
            check({31'h0, cal[0]}, {31'h0, i == 1 || i == 2});
        end
        // all timers unused, conditions random
        for (int i = 0; i < 30; i++) begin
            cond(4'($random(seed)), 4'($random(seed)));
            step(1);
            check({28'h0, tmr}, 32'h0);
        end
        cond(4'h0, 4'h0);
        wreg(8'h84, 32'h4);
        wreg(8'h80, 32'h2);
        wreg(8'h81, 32'h2);
        wreg(8'h82, 32'h2);
        wreg(8'h88, 32'h1);
        wreg(8'h89, 32'h00020002);
        wreg(8'h8A, 32'h00010002);
        wreg(8'h8C, 32'h3);
        wreg(8'h8D, 32'h2);
        wreg(8'h8E, 32'h2);
        cond(4'h2, 4'h0);
        tchk(3, 1, 1'b1);
        cond(4'h0, 4'h0);
        tchk(3, 1, 1'b1);
        cond(4'h2, 4'h2);
        tchk(3, 1, 1'b0);
        cond(4'h1, 4'h0);
        tchk(3, 0, 1'b1);
        tchk(40, 0, 1'b0);
        cond(4'h0, 4'h0);
        tchk(3, 0, 1'b1);
        tchk(40, 0, 1'b0);
        tchk(1, 1, 1'b0);
        // two hours on, two minutes off; first unit may be short
        cond(4'h4, 4'h0);
        tchk(80, 2, 1'b0);
        tchk(120, 2, 1'b1);
        cond(4'h0, 4'h0);
        tchk(25, 2, 1'b1);
        tchk(45, 2, 1'b0);
        cond(4'h8, 4'h0);
        tchk(3, 3, 1'b1);
        hi = 0;
        lo = 0;
        for (int i = 0; i < 80; i++) begin
            step(1);
            if (tmr[3] === 1'b1) hi++;
            if (tmr[3] === 1'b0) lo++;
        end
        check({30'h0, hi > 0, lo > 0}, 32'h3);
        cond(4'h8, 4'h8);
        tchk(3, 3, 1'b0);
        cond(4'h0, 4'h0);
        tchk(3, 3, 1'b0);
        close_out();
    end
endmodule // testbench
